// File: design/scg_pkg.sv
// shared constants for the sleep-mode clock gate register block
package scg_pkg;

  // bus and register geometry
  localparam int SCG_DW = 32;
  localparam int SCG_AW = 12;
  localparam int SCG_UNITS = 12;

  // register byte offsets (low address bits)
  localparam logic [SCG_AW-1:0] SCG_SLEEP_OFF = 12'h114;
  localparam logic [SCG_AW-1:0] SCG_CTRL_OFF = 12'h118;
  localparam logic [SCG_AW-1:0] SCG_STAT_OFF = 12'h11C;
  localparam logic [SCG_AW-1:0] SCG_FAULT_OFF = 12'h120;

  // reset values
  localparam logic [SCG_DW-1:0] SCG_RST_WORD = 32'h0000_0000;
  localparam logic [SCG_UNITS-1:0] SCG_RST_UNITS = 12'h000;

  // writable bit positions of the gate layout
  localparam logic [SCG_DW-1:0] SCG_GATE_MASK = 32'h0707_1117;

  // control register fields
  localparam int SCG_CTRL_ACG_BIT = 0;
  // status register field holding the one-hot power mode
  localparam int SCG_STAT_MODE_LSB = 29;

  // gate bit of each unit: async serial 0..2, sync serial, quadrature,
  // two-wire, counters 0..2, comparators 0..2
  localparam int SCG_UNIT_POS [SCG_UNITS] = '{0, 1, 2, 4, 8, 12,
                                              16, 17, 18, 24, 25, 26};

  // htrans and hresp encodings used by the slave
  localparam logic [1:0] SCG_HTRANS_NONSEQ = 2'h2;
  localparam logic SCG_HRESP_OKAY = 1'h0;

  // power mode that selects the enable source
  typedef enum logic [2:0] {
    SCG_MODE_RUN = 3'b001,
    SCG_MODE_SLEEP = 3'b010,
    SCG_MODE_DEEP = 3'b100
  } scg_mode_t;

endpackage

// File: design/scg_sleep_clock_gate.sv
`timescale 1ns/10ps
`default_nettype none

module scg_sleep_clock_gate
  import scg_pkg::*;
(
  // system clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [SCG_DW-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [SCG_DW-1:0] hrdata,
  output logic hresp,
  // power state from the core, same clock
  input wire logic core_sleeping,
  input wire logic core_deep_sleep,
  // companion run and deep-sleep enables, one per unit
  input wire logic [SCG_UNITS-1:0] run_gate_in,
  input wire logic [SCG_UNITS-1:0] deep_gate_in,
  // one-cycle access strobes from the peripheral bridge
  input wire logic [SCG_UNITS-1:0] unit_access_req,
  // clock enables to the unit gating cells
  output logic [SCG_UNITS-1:0] unit_clk_en,
  // one-cycle bus fault strobes back to the bridge
  output logic [SCG_UNITS-1:0] unit_bus_fault
);

  // address phase accepted this cycle
  logic addr_take;
  // captured data phase
  logic dp_valid_r;
  logic dp_write_r;
  logic [SCG_AW-1:0] dp_addr_r;
  // write strobes per register, data phase
  logic wr_sleep;
  logic wr_ctrl;
  logic wr_fault;
  // sleep-mode gate register, packed layout
  logic [SCG_DW-1:0] sleep_gate_r;
  logic [SCG_DW-1:0] sleep_gate_nxt;
  // auto clock gating select
  logic auto_clock_gating_select_r;
  logic auto_clock_gating_select_nxt;
  // sticky fault flags, packed layout
  logic [SCG_DW-1:0] fault_r;
  logic [SCG_DW-1:0] fault_nxt;
  // fault set and clear terms, packed layout
  logic [SCG_DW-1:0] fault_set;
  logic [SCG_DW-1:0] fault_clr;
  // power mode
  scg_mode_t mode_r;
  scg_mode_t mode_nxt;
  // applied enables and their next value
  logic [SCG_UNITS-1:0] unit_clk_en_r;
  logic [SCG_UNITS-1:0] unit_clk_en_nxt;
  // fault strobes
  logic [SCG_UNITS-1:0] unit_bus_fault_r;
  logic [SCG_UNITS-1:0] unit_bus_fault_nxt;
  // sleep enables unpacked per unit
  logic [SCG_UNITS-1:0] sleep_units;
  // applied enables packed into the gate layout
  logic [SCG_DW-1:0] en_word;
  // read mux result and bus outputs
  logic [SCG_DW-1:0] rd_word;
  logic [SCG_DW-1:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;

  // a transfer starts on a selected nonseq address phase
  assign addr_take = hsel && (htrans == SCG_HTRANS_NONSEQ) && hready;

  // capture the address phase for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= '0;
    end else if (hready) begin
      // a stretched phase keeps the captured address; a new one replaces it
      // idle cycles clear the valid flag so no stale write repeats
      dp_valid_r <= addr_take;
      dp_write_r <= hwrite;
      dp_addr_r <= haddr[SCG_AW-1:0];
    end
  end

  // per-register write strobes, active in the data phase
  // hwdata is only valid here, one cycle after the address was taken
  assign wr_sleep = dp_valid_r && dp_write_r && (dp_addr_r == SCG_SLEEP_OFF);
  assign wr_ctrl = dp_valid_r && dp_write_r && (dp_addr_r == SCG_CTRL_OFF);
  assign wr_fault = dp_valid_r && dp_write_r && (dp_addr_r == SCG_FAULT_OFF);

  // next value of the gate register
  always_comb begin
    // hold the stored enables unless the bus writes them
    sleep_gate_nxt = sleep_gate_r;
    // a write replaces every unit bit at once
    if (wr_sleep) begin
      // only unit positions store, the rest stay zero
      sleep_gate_nxt = hwdata & SCG_GATE_MASK;
    end
  end

  // sleep-mode gate register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // every unit's sleep-mode enable starts cleared until software sets it
      sleep_gate_r <= SCG_RST_WORD;
    end else begin
      // load the next value every cycle
      sleep_gate_r <= sleep_gate_nxt;
    end
  end

  // next value of the auto gating select
  always_comb begin
    // keep the selection between writes
    auto_clock_gating_select_nxt = auto_clock_gating_select_r;
    // only bit zero of the control word is stored
    if (wr_ctrl) begin
      auto_clock_gating_select_nxt = hwdata[SCG_CTRL_ACG_BIT];
    end
  end

  // auto gating select register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // auto gating off, so run enables govern after reset
      auto_clock_gating_select_r <= 1'b0;
    end else begin
      // load the next value every cycle
      auto_clock_gating_select_r <= auto_clock_gating_select_nxt;
    end
  end

  // choose which enable set governs the units
  always_comb begin
    // deep sleep wins when the core reports both states
    if (auto_clock_gating_select_r && core_deep_sleep) begin
      mode_nxt = SCG_MODE_DEEP;
    end else if (auto_clock_gating_select_r && core_sleeping) begin
      mode_nxt = SCG_MODE_SLEEP;
    end else begin
      // without auto gating the run enables stay in force
      mode_nxt = SCG_MODE_RUN;
    end
  end

  // power mode register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // run mode until auto gating is on and the core reports a sleep state
      mode_r <= SCG_MODE_RUN;
    end else begin
      // mirrors the mode that chose the applied enables
      mode_r <= mode_nxt;
    end
  end

  // per-unit enable selection, unpacking and fault detection
  genvar gu;
  generate
    for (gu = 0; gu < SCG_UNITS; gu++) begin : g_unit
      // enable picked for this unit by the power mode
      logic en_pick;

      // pick the unit's gate bit from its fixed position
      assign sleep_units[gu] = sleep_gate_r[SCG_UNIT_POS[gu]];

      // the enable source follows the power mode; run is the fallback
      always_comb begin
        en_pick = run_gate_in[gu];
        unique case (mode_nxt)
          // sleep with auto gating: this register decides
          SCG_MODE_SLEEP: en_pick = sleep_units[gu];
          // deep sleep: the companion deep-sleep enables decide
          SCG_MODE_DEEP: en_pick = deep_gate_in[gu];
          // run: the companion run enables decide
          SCG_MODE_RUN: en_pick = run_gate_in[gu];
        endcase
      end

      // each unit drives only its own bit of the next-enable vector
      assign unit_clk_en_nxt[gu] = en_pick;

      // an access to an unclocked unit faults instead of completing
      assign unit_bus_fault_nxt[gu] = unit_access_req[gu] && !unit_clk_en_r[gu];
    end
  endgenerate

  // applied enables and fault strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // all units unclocked and no fault pending
      unit_clk_en_r <= SCG_RST_UNITS;
      unit_bus_fault_r <= SCG_RST_UNITS;
    end else begin
      // enables lag the mode and inputs by one edge
      unit_clk_en_r <= unit_clk_en_nxt;
      unit_bus_fault_r <= unit_bus_fault_nxt;
    end
  end

  // pack per-unit vectors back into the gate layout
  always_comb begin
    // unused positions stay zero in both words
    en_word = SCG_RST_WORD;
    fault_set = SCG_RST_WORD;
    for (int i = 0; i < SCG_UNITS; i++) begin
      en_word[SCG_UNIT_POS[i]] = unit_clk_en_r[i];
      fault_set[SCG_UNIT_POS[i]] = unit_bus_fault_nxt[i];
    end
  end

  // write-one-to-clear; a new fault wins over its clear
  // writing ones to unit bits clears their flags
  assign fault_clr = wr_fault ? (hwdata & SCG_GATE_MASK) : SCG_RST_WORD;
  assign fault_nxt = (fault_r & ~fault_clr) | fault_set;

  // sticky fault flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // no fault recorded after reset
      fault_r <= SCG_RST_WORD;
    end else begin
      // flags stay set until software clears them
      fault_r <= fault_nxt;
    end
  end

  // read mux; sleep, control and fault reads use next values so a read right after a write sees it
  always_comb begin
    // bits not named by a register read zero
    rd_word = SCG_RST_WORD;
    unique case (haddr[SCG_AW-1:0])
      SCG_SLEEP_OFF: begin
        // unused positions are never stored, so they read zero
        rd_word = sleep_gate_nxt;
      end
      SCG_CTRL_OFF: begin
        // only the auto gating select is visible
        rd_word[SCG_CTRL_ACG_BIT] = auto_clock_gating_select_nxt;
      end
      SCG_STAT_OFF: begin
        // applied enables plus the current power mode
        rd_word = en_word;
        rd_word[SCG_STAT_MODE_LSB +: 3] = mode_r;
      end
      SCG_FAULT_OFF: begin
        // a flag set in this cycle already shows
        rd_word = fault_nxt;
      end
      default: begin
        // unmapped offsets read zero
        rd_word = SCG_RST_WORD;
      end
    endcase
  end

  // read data is loaded at the address phase, shown in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // read data starts at zero after reset
      hrdata_r <= SCG_RST_WORD;
    end else if (addr_take && !hwrite) begin
      // held until the next read so the master may sample late
      hrdata_r <= rd_word;
    end
  end

  // zero-wait slave, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // ready already during reset so the bus never stalls
      hreadyout_r <= 1'b1;
      hresp_r <= SCG_HRESP_OKAY;
    end else begin
      // no wait states and no error responses
      hreadyout_r <= 1'b1;
      hresp_r <= SCG_HRESP_OKAY;
    end
  end

  // outputs straight from flip-flops
  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = hresp_r;
  assign unit_clk_en = unit_clk_en_r;
  assign unit_bus_fault = unit_bus_fault_r;

endmodule

`default_nettype wire

// File: tb/scg_sleep_clock_gate_properties.sv
`timescale 1ns/10ps
`default_nettype none
module scg_sleep_clock_gate_properties
  import scg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [SCG_DW-1:0] hrdata,
  input wire logic hresp,
  input wire logic core_sleeping,
  input wire logic core_deep_sleep,
  input wire logic [SCG_UNITS-1:0] run_gate_in,
  input wire logic [SCG_UNITS-1:0] unit_access_req,
  input wire logic [SCG_UNITS-1:0] unit_clk_en,
  input wire logic [SCG_UNITS-1:0] unit_bus_fault
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // read address phase taken this edge
  wire logic rd_go = hsel && htrans == SCG_HTRANS_NONSEQ && hready && !hwrite;
  // unit enables placed at their gate bits
  function automatic logic [31:0] spread(input logic [SCG_UNITS-1:0] e);
    spread = '0;
    for (int u = 0; u < SCG_UNITS; u++) spread[SCG_UNIT_POS[u]] = e[u];
  endfunction
  a_reset_clear: assert property (disable iff (1'b0)
    !hresetn |-> !(|unit_clk_en) && !(|unit_bus_fault)) else $error("outputs set in reset");
  // run mode held two edges, so a lagging mode register cannot fire it
  a_run_follow: assert property (!core_sleeping && !core_deep_sleep &&
    $past(!core_sleeping && !core_deep_sleep) |=> unit_clk_en == $past(run_gate_in))
    else $error("run enables not applied");
  a_fault_pulse: assert property (1'b1 |=>
    unit_bus_fault == $past(unit_access_req & ~unit_clk_en)) else $error("fault strobe wrong");
  a_stat_map: assert property (rd_go && haddr[11:0] == SCG_STAT_OFF |=>
    (hrdata & 32'h1FFF_FFFF) == spread($past(unit_clk_en))) else $error("status map wrong");
  a_unused_zero: assert property (rd_go && haddr[11:0] == SCG_SLEEP_OFF |=>
    (hrdata & ~SCG_GATE_MASK) == '0) else $error("unused bits not zero");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not zero-wait okay");
  // main scenarios reached
  c_fault: cover property (|unit_bus_fault);
  c_stat: cover property (rd_go && haddr[11:0] == SCG_STAT_OFF);
  c_sleep_en: cover property (core_sleeping && |unit_clk_en);
endmodule
`default_nettype wire

// File: tb/scg_sleep_clock_gate_test.sv
`timescale 1ns/10ps
`default_nettype none
module scg_sleep_clock_gate_test
  import scg_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q, d;
  logic [1:0] htrans;
  logic core_sleeping, core_deep_sleep;
  logic [SCG_UNITS-1:0] run_gate_in, deep_gate_in, unit_access_req, unit_clk_en;
  logic [SCG_UNITS-1:0] unit_bus_fault, e;
  int failures = 0;
  int tests_run = 0;
  int seed = 32'hB535;
  // hsize is ignored by the slave, so it is tied to word size
  scg_sleep_clock_gate i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout, .hrdata, .hresp, .core_sleeping,
    .core_deep_sleep, .run_gate_in, .deep_gate_in, .unit_access_req, .unit_clk_en,
    .unit_bus_fault);
  // single slave: its ready is the bus ready
  assign hready = hreadyout;
  // gate word to per-unit enables
  function automatic logic [SCG_UNITS-1:0] gather(input logic [31:0] w);
    for (int u = 0; u < SCG_UNITS; u++) gather[u] = w[SCG_UNIT_POS[u]];
  endfunction
  // per-unit enables to gate word
  function automatic logic [31:0] spread(input logic [SCG_UNITS-1:0] v);
    spread = '0;
    for (int u = 0; u < SCG_UNITS; u++) spread[SCG_UNIT_POS[u]] = v[u];
  endfunction
  task automatic wrap_up;
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // wait for hready at an edge, bounded
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      failures++;
      wrap_up;
    end
  endtask
  // one single-word transfer; read data lands in q
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= SCG_HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy;
    q = hrdata;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(q, exp);
  endtask
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b1;
    {hsel, hwrite, core_sleeping, core_deep_sleep, htrans, haddr, hwdata} = '0;
    {run_gate_in, deep_gate_in, unit_access_req} = '0;
    #1 hresetn = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(SCG_SLEEP_OFF, SCG_RST_WORD);
    chk(32'(unit_clk_en), 32'h0);
    // random gate words; run mode ignores sleep state while auto gating is off
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      run_gate_in <= SCG_UNITS'($random(seed));
      deep_gate_in <= SCG_UNITS'($random(seed));
      core_sleeping <= 1'($random(seed));
      bus(SCG_SLEEP_OFF, 1'b1, d);
      rd(SCG_SLEEP_OFF, d & SCG_GATE_MASK);
      chk(32'(unit_clk_en), 32'(run_gate_in));
    end
    bus(SCG_CTRL_OFF, 1'b1, 32'h1);
    rd(SCG_CTRL_OFF, 32'h1);
    core_sleeping <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(32'(unit_clk_en), 32'(gather(d)));
    rd(SCG_STAT_OFF, spread(gather(d)) | (32'(SCG_MODE_SLEEP) << SCG_STAT_MODE_LSB));
    // every unit touched once; enabled ones must not fault
    unit_access_req <= '1;
    @(posedge hclk);
    unit_access_req <= '0;
    @(posedge hclk);
    e = ~gather(d);
    chk(32'(unit_bus_fault), 32'(e));
    rd(SCG_FAULT_OFF, spread(e));
    bus(SCG_FAULT_OFF, 1'b1, 32'hFFFF_FFFF);
    rd(SCG_FAULT_OFF, 32'h0);
    // a fault in the cycle of its clear stays set
    fork
      bus(SCG_FAULT_OFF, 1'b1, 32'hFFFF_FFFF);
      begin
        @(posedge hclk);
        unit_access_req <= e;
        @(posedge hclk);
        unit_access_req <= '0;
      end
    join
    rd(SCG_FAULT_OFF, spread(e));
    // read-modify-write flips one unit and hands unused bits back as read
    bus(SCG_SLEEP_OFF, 1'b0, 32'h0);
    chk(q & ~SCG_GATE_MASK, 32'h0);
    d = q ^ spread(12'h001);
    bus(SCG_SLEEP_OFF, 1'b1, d);
    rd(SCG_SLEEP_OFF, d & SCG_GATE_MASK);
    chk(32'(unit_clk_en), 32'(gather(d)));
    core_deep_sleep <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(32'(unit_clk_en), 32'(deep_gate_in));
    // unmapped offset ignores writes and reads zero
    bus(12'h200, 1'b1, 32'hFFFF_FFFF);
    rd(12'h200, 32'h0);
    // second reset in mid-run
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    rd(SCG_SLEEP_OFF, SCG_RST_WORD);
    rd(SCG_CTRL_OFF, SCG_RST_WORD);
    rd(SCG_FAULT_OFF, SCG_RST_WORD);
    chk(32'(unit_clk_en), 32'(run_gate_in));
    wrap_up;
  end
endmodule
bind scg_sleep_clock_gate scg_sleep_clock_gate_properties i_props (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp, .core_sleeping,
  .core_deep_sleep, .run_gate_in, .unit_access_req, .unit_clk_en, .unit_bus_fault);
`default_nettype wire
